// ==== txirq_pkg.sv ====
// Shared constants and carriers for the transmit interrupt and channel B valid block
package txirq_pkg;
	localparam logic [7:0] ADDR_RX_B_VALID   = 8'h0c;
	localparam logic [7:0] ADDR_TX_IRQ_EN    = 8'h0d;
	localparam logic [7:0] ADDR_TX_IRQ_STAT  = 8'h0e;
	localparam logic [7:0] TX_IRQ_EN_RESET   = 8'h00;
	localparam logic [7:0] TX_IRQ_STAT_RESET = 8'h00;
	localparam logic [7:0] RX_B_VALID_RESET  = 8'h00;
	localparam int         BIT_UNDERFLOW     = 3;
	localparam int         BIT_OVERFLOW      = 2;
	localparam int         BIT_DONE          = 1;
	localparam int         BIT_EMPTY         = 0;
	localparam logic [3:0] RC_CLEAR_MASK     = 4'he;

	// Register port request from the serial front end
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_s;

	// Events reported by the transmit shifter
	typedef struct packed {
		logic bit_sent;
		logic sample_req;
		logic hold_to_shift;
		logic byte_done;
	} tx_evt_s;
endpackage

// ==== tx_flag_cell.sv ====
// One sticky status flag with set-over-clear priority; transmit off (tx_on low) clears it ahead of set
`timescale 1ns/1ps
module tx_flag_cell (
	input  wire logic sys_clk,
	input  wire logic rst_n,
	input  wire logic clk_en,
	input  wire logic set,
	input  wire logic clr,
	input  wire logic tx_on,
	output logic      flag
);
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			flag <= 1'b0;
		end else if (clk_en) begin
			if (!tx_on)
				flag <= 1'b0;
			else if (set)
				flag <= 1'b1;
			else if (clr)
				flag <= 1'b0;
		end
	end
endmodule

// ==== tx_serdes_irq.sv ====
// Transmit serializer interrupt logic with channel B valid mask
`timescale 1ns/1ps
module tx_serdes_irq (
	input  wire logic               sys_clk,
	input  wire logic               rst_n,
	input  wire logic               clk_en,
	input  wire txirq_pkg::reg_req_s req,
	output logic [7:0]              rdata,
	input  wire logic               tx_enable,
	input  wire logic               hold_write,
	input  wire txirq_pkg::tx_evt_s  evt,
	input  wire logic               rx_b_load,
	input  wire logic [7:0]         rx_b_valid_in,
	output logic                    rx_b_all_valid,
	output logic                    irq
);
	logic [3:0] en_q;
	logic [7:0] rx_b_valid_q;
	logic       hold_full_q;
	logic       sent_any_q;
	logic [3:0] set_v;
	logic [3:0] clr_v;
	logic [3:0] stat;
	logic       stat_rd;

	assign stat_rd = req.rd && req.addr == txirq_pkg::ADDR_TX_IRQ_STAT;

	// Enable register; upper bits are not stored so they always read zero
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			en_q <= txirq_pkg::TX_IRQ_EN_RESET[3:0];
		else if (clk_en && req.wr && req.addr == txirq_pkg::ADDR_TX_IRQ_EN)
			en_q <= req.wdata[3:0];
	end

	// Channel B valid mask, captured with each received byte
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			rx_b_valid_q <= txirq_pkg::RX_B_VALID_RESET;
		else if (clk_en && rx_b_load)
			rx_b_valid_q <= rx_b_valid_in;
	end
	assign rx_b_all_valid = &rx_b_valid_q;

	// Holding register occupancy and the first-bit qualifier
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_full_q <= 1'b0;
			sent_any_q  <= 1'b0;
		end else if (clk_en) begin
			if (!tx_enable) begin
				hold_full_q <= 1'b0;
				sent_any_q  <= 1'b0;
			end else begin
				if (hold_write)
					hold_full_q <= 1'b1;
				else if (evt.hold_to_shift)
					hold_full_q <= 1'b0;
				if (evt.bit_sent)
					sent_any_q <= 1'b1;
			end
		end
	end

	always_comb begin
		set_v = 4'h0;
		set_v[txirq_pkg::BIT_UNDERFLOW] = evt.sample_req && !hold_full_q && sent_any_q;
		// A write landing on the load cycle still counts: the old byte had not moved yet
		set_v[txirq_pkg::BIT_OVERFLOW]  = hold_write && hold_full_q;
		set_v[txirq_pkg::BIT_DONE]      = evt.byte_done && !hold_full_q && sent_any_q;
		set_v[txirq_pkg::BIT_EMPTY]     = evt.hold_to_shift && hold_full_q;
		clr_v = stat_rd ? txirq_pkg::RC_CLEAR_MASK : 4'h0;
		clr_v[txirq_pkg::BIT_EMPTY] = hold_write;
	end

	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_flag
			tx_flag_cell u_flag (
				.sys_clk (sys_clk),
				.rst_n   (rst_n),
				.clk_en  (clk_en),
				.set     (set_v[i]),
				.clr     (clr_v[i]),
				.tx_on   (tx_enable),
				.flag    (stat[i])
			);
		end
	endgenerate

	assign irq = |(stat & en_q);

	// Read data registered one cycle after the read strobe
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			rdata <= 8'h00;
		else if (clk_en && req.rd) begin
			unique case (req.addr)
				txirq_pkg::ADDR_RX_B_VALID:  rdata <= rx_b_valid_q;
				txirq_pkg::ADDR_TX_IRQ_EN:   rdata <= {4'h0, en_q};
				txirq_pkg::ADDR_TX_IRQ_STAT: rdata <= {4'h0, stat};
				default:                     rdata <= 8'h00;
			endcase
		end
	end

	// Checks look one cycle after the event that should move a flag
	a_under_after_bit: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		clk_en && !sent_any_q && !stat[txirq_pkg::BIT_UNDERFLOW]
		|=> !stat[txirq_pkg::BIT_UNDERFLOW])
		else $error("underflow before first bit");
	a_under_sets: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		clk_en && tx_enable && evt.sample_req && !hold_full_q && sent_any_q
		|=> stat[txirq_pkg::BIT_UNDERFLOW])
		else $error("underflow not flagged");
	a_done_needs_bit: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		$rose(stat[txirq_pkg::BIT_DONE])
		|-> $past(sent_any_q))
		else $error("done before first bit");
	a_done_sets: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		clk_en && tx_enable && evt.byte_done && !hold_full_q && sent_any_q
		|=> stat[txirq_pkg::BIT_DONE])
		else $error("done not flagged");

	a_over_needs_write: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		$rose(stat[txirq_pkg::BIT_OVERFLOW])
		|-> $past(hold_write))
		else $error("overflow without holding write");
	a_overflow_sets: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		clk_en && tx_enable && hold_write && hold_full_q
		|=> stat[txirq_pkg::BIT_OVERFLOW])
		else $error("overflow not flagged");
	a_empty_on_load: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		clk_en && tx_enable && evt.hold_to_shift && hold_full_q && !hold_write
		|=> stat[txirq_pkg::BIT_EMPTY])
		else $error("empty not flagged");
	a_empty_needs_load: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		$rose(stat[txirq_pkg::BIT_EMPTY])
		|-> $past(evt.hold_to_shift))
		else $error("empty without holding load");
	a_empty_cleared: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		clk_en && hold_write && !(evt.hold_to_shift && hold_full_q)
		|=> !stat[txirq_pkg::BIT_EMPTY])
		else $error("empty not cleared by write");

	a_read_clears: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		clk_en && stat_rd && !set_v[txirq_pkg::BIT_DONE]
		|=> !stat[txirq_pkg::BIT_DONE])
		else $error("done not cleared by read");
	a_read_keeps_empty: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		clk_en && tx_enable && stat_rd && stat[txirq_pkg::BIT_EMPTY] && !hold_write
		|=> stat[txirq_pkg::BIT_EMPTY])
		else $error("empty cleared by status read");
	a_idle_zero: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		clk_en && !tx_enable
		|=> stat == 4'h0)
		else $error("status set outside transmit");
	a_irq_gate: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		clk_en && tx_enable && set_v[txirq_pkg::BIT_OVERFLOW]
		&& en_q[txirq_pkg::BIT_OVERFLOW] && !(req.wr && req.addr == txirq_pkg::ADDR_TX_IRQ_EN)
		|=> irq)
		else $error("irq missing for enabled status");

	a_stat_upper: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		$past(clk_en && stat_rd)
		|-> rdata[7:4] == 4'h0)
		else $error("reserved status bits set");
	a_rdata_stat: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		clk_en && stat_rd
		|=> rdata == {4'h0, $past(stat)})
		else $error("status read data wrong");
	a_en_write: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		clk_en && req.wr && req.addr == txirq_pkg::ADDR_TX_IRQ_EN
		|=> en_q == $past(req.wdata[3:0]))
		else $error("enable write not stored");
	a_mask_load: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		clk_en && rx_b_load
		|=> rx_b_valid_q == $past(rx_b_valid_in))
		else $error("valid mask not loaded");
	a_all_valid: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		clk_en && rx_b_load
		|=> rx_b_all_valid == (&$past(rx_b_valid_in)))
		else $error("all-valid mismatch");
	// A frozen cycle must leave the status, read data and enable registers untouched
	a_freeze_hold: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		!clk_en
		|=> $stable(stat) && $stable(rdata) && $stable(en_q))
		else $error("state moved while clock enable low");
endmodule

// ==== host_port.sv ====
// Host side model of the serial register port
`timescale 1ns/1ps
module host_port (
	input  wire logic          sys_clk,
	input  wire logic [7:0]    rdata,
	output txirq_pkg::reg_req_s req
);
	initial req = '0;
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		req <= '{1'b0, 1'b1, a, (a == txirq_pkg::ADDR_TX_IRQ_EN) ? (d & 8'h0f) : d};
		@(posedge sys_clk);
		req <= '{1'b0, 1'b0, ~a, ~d};
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		req <= '{1'b1, 1'b0, a, 8'h00};
		@(posedge sys_clk);
		req <= '{1'b0, 1'b0, ~a, 8'hff};
		#1 d = rdata;
	endtask
endmodule

// ==== tx_serdes_irq_tb.sv ====
// Self-checking bench for the transmit interrupt and channel B valid block
`timescale 1ns/1ps
module tx_serdes_irq_tb;
	logic                sys_clk, rst_n, tx_enable, hold_write, rx_b_load, rx_b_all_valid, irq;
	logic                clk_en;
	logic [7:0]          rdata, rx_b_valid_in;
	txirq_pkg::reg_req_s req;
	txirq_pkg::tx_evt_s  evt;
	int                  mismatches = 0, samples_checked = 0, cycles = 0;
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	host_port u_host_port (.sys_clk(sys_clk), .rdata(rdata), .req(req));
	tx_serdes_irq u_tx_serdes_irq (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .req(req),
		.rdata(rdata), .tx_enable(tx_enable), .hold_write(hold_write), .evt(evt),
		.rx_b_load(rx_b_load), .rx_b_valid_in(rx_b_valid_in),
		.rx_b_all_valid(rx_b_all_valid), .irq(irq));
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		samples_checked++;
		if (s !== e) begin
			mismatches++;
			$display("ERROR t=%0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		u_host_port.rd(a, d);
		chk(d, e);
	endtask
	// Bits: hold write, bit sent, sample request, holding to shifter, byte done
	task automatic pulse(input logic [4:0] v);
		@(posedge sys_clk);
		{hold_write, evt} <= v;
		@(posedge sys_clk);
		{hold_write, evt} <= 5'h00;
	endtask
	// Generous ceiling: the sequence needs well under 200 cycles
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			test_done();
		end
	end
	initial begin
		{rst_n, tx_enable, hold_write, rx_b_load, rx_b_valid_in, evt} = '0;
		clk_en = 1'b1;
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'b1;
		rc(txirq_pkg::ADDR_TX_IRQ_EN, 8'h00);
		@(posedge sys_clk);
		tx_enable <= 1'b1;
		u_host_port.wr(txirq_pkg::ADDR_TX_IRQ_STAT, 8'hff);
		rc(txirq_pkg::ADDR_TX_IRQ_STAT, 8'h00);
		u_host_port.wr(txirq_pkg::ADDR_TX_IRQ_EN, 8'hff);
		rc(txirq_pkg::ADDR_TX_IRQ_EN, 8'h0f);
		pulse(5'h05);
		rc(txirq_pkg::ADDR_TX_IRQ_STAT, 8'h00);
		chk({7'h0, irq}, 8'h00);
		pulse(5'h10);
		pulse(5'h02);
		rc(txirq_pkg::ADDR_TX_IRQ_STAT, 8'h01);
		chk({7'h0, irq}, 8'h01);
		pulse(5'h10);
		pulse(5'h10);
		rc(txirq_pkg::ADDR_TX_IRQ_STAT, 8'h04);
		rc(txirq_pkg::ADDR_TX_IRQ_STAT, 8'h00);
		pulse(5'h02);
		pulse(5'h08);
		pulse(5'h04);
		pulse(5'h01);
		rc(txirq_pkg::ADDR_TX_IRQ_STAT, 8'h0b);
		rc(txirq_pkg::ADDR_TX_IRQ_STAT, 8'h01);
		u_host_port.wr(txirq_pkg::ADDR_TX_IRQ_EN, 8'h00);
		rc(txirq_pkg::ADDR_TX_IRQ_EN, 8'h00);
		chk({7'h0, irq}, 8'h00);
		rc(txirq_pkg::ADDR_TX_IRQ_STAT, 8'h01);
		// A holding write seen while frozen must not clear the empty flag
		@(posedge sys_clk);
		clk_en <= 1'b0;
		pulse(5'h10);
		clk_en <= 1'b1;
		rc(txirq_pkg::ADDR_TX_IRQ_STAT, 8'h01);
		@(posedge sys_clk);
		tx_enable <= 1'b0;
		rc(txirq_pkg::ADDR_TX_IRQ_STAT, 8'h00);
		for (int i = 0; i < 2; i++) begin
			@(posedge sys_clk);
			rx_b_valid_in <= i ? 8'hff : 8'ha5;
			rx_b_load <= 1'b1;
			@(posedge sys_clk);
			rx_b_load <= 1'b0;
			rc(txirq_pkg::ADDR_RX_B_VALID, i ? 8'hff : 8'ha5);
			chk({7'h0, rx_b_all_valid}, 8'(i));
		end
		rc(8'h20, 8'h00);
		test_done();
	end
endmodule
